// ---- rtl/tdm_multiprocessor_serial_port.sv ----
// multiplexed serial port: register file, slot timing, shift paths
// assumes bus pins tied by the board and bus clock far below ref clock
// pin output enables are active low, low only in own slots
`timescale 1ns/10ps
module tdm_multiprocessor_serial_port (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// register port
	input wire tdm_port_pkg::reg_req_t req_in,
	output logic [tdm_port_pkg::data_w-1:0] rdata_out,
	// shared bus pins
	input wire tdm_port_pkg::bus_in_t bus_in,
	output tdm_port_pkg::bus_out_t bus_out,
	// interrupt
	output logic irq_out
);
	import tdm_port_pkg::*;

	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic clk_prev;
	// bus clock edges seen about two reference cycles late
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else begin
			sync1 <= {bus_in.clk, bus_in.dat, bus_in.adr};
			sync2 <= sync1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			clk_prev <= 1'b0;
		else
			clk_prev <= sync2[2];
	end
	wire bclk = sync2[2];
	wire bdat = sync2[1];
	wire badr = sync2[0];
	wire rise = bclk & ~clk_prev;
	wire fall = ~bclk & clk_prev;

	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	logic [data_w-1:0] slot_select;
	logic [data_w-1:0] rt_address;
	logic [data_w-1:0] port_control;
	logic [data_w-1:0] tx_holding;
	logic [data_w-1:0] rx_holding;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic tx_full;
	logic rx_full;
	logic align_seen;

	// ---------------------------------------------
	// write and read decode
	// ---------------------------------------------
	wire mode_en = port_control[bit_mode_en];
	wire wr_ctl = req_in.wr & (req_in.addr == off_port_control);
	wire wr_sel = req_in.wr & (req_in.addr == off_slot_select);
	wire wr_rta = req_in.wr & (req_in.addr == off_rt_address);
	// one word per enable: no refill while the port runs
	wire wr_txh = req_in.wr & (req_in.addr == off_tx_holding) &
		~mode_en;
	wire wr_ist = req_in.wr & (req_in.addr == off_irq_status);
	wire wr_imk = req_in.wr & (req_in.addr == off_irq_mask);
	wire rd_rxh = req_in.rd & (req_in.addr == off_rx_holding) &
		~mode_en;
	wire rd_ast = req_in.rd & (req_in.addr == off_addr_status);

	// ---------------------------------------------
	// address fields
	// ---------------------------------------------
	wire [7:0] own_receive_addr = rt_address[7:0];
	wire [7:0] dest_transmit_addr = rt_address[15:8];

	// ---------------------------------------------
	// slot timing and shift paths
	// ---------------------------------------------
	logic [3:0] bit_cnt;
	logic [2:0] slot_cnt;
	logic [word_bits-1:0] transmit_shift;
	logic [word_bits-1:0] mux_receive_shift;
	logic [7:0] addr_shift;
	logic [7:0] addr_out_shift;
	logic tx_loaded;
	logic addr_hit;
	wire word_end = rise & (bit_cnt == bit_cnt_last);
	wire [2:0] next_slot = (slot_cnt == slot_last) ? 3'h0 :
		slot_cnt + 3'h1;
	// a slot is loaded at the end of the slot before it
	wire next_slot_on = mode_en & slot_select[next_slot];
	wire load_tx = word_end & tx_full & next_slot_on;
	wire shift_out = fall & tx_loaded & (bit_cnt != 4'h0);
	wire [7:0] next_addr_shift = {addr_shift[6:0], badr};
	wire addr_match = next_addr_shift == own_receive_addr;
	// only the eighth bit of a slot closes the address field
	wire next_hit = (bit_cnt == addr_bit_last) ? addr_match :
		addr_hit;
	// own transmit slots are never captured
	wire rx_done = word_end & mode_en & addr_hit & ~tx_loaded;

	// ---------------------------------------------
	// slot counters
	// ---------------------------------------------
	// first rise after enable is bit zero of slot zero
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			bit_cnt <= 4'h0;
		else if (!mode_en)
			bit_cnt <= 4'h0;
		else if (rise)
			bit_cnt <= bit_cnt + 4'h1;
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			slot_cnt <= 3'h0;
		else if (!mode_en)
			slot_cnt <= 3'h0;
		else if (word_end)
			slot_cnt <= next_slot;
	end

	// ---------------------------------------------
	// receive path
	// ---------------------------------------------
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			mux_receive_shift <= zero_word;
		else if (mode_en & rise)
			mux_receive_shift <= {mux_receive_shift[word_bits-2:0], bdat};
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			addr_shift <= 8'h00;
		else if (mode_en & rise)
			addr_shift <= next_addr_shift;
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			addr_hit <= 1'b0;
		else if (!mode_en)
			addr_hit <= 1'b0;
		else if (rise)
			addr_hit <= word_end ? 1'b0 : next_hit;
	end

	// ---------------------------------------------
	// transmit path
	// ---------------------------------------------
	// drive on falling edge, valid before next rising sample
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			transmit_shift <= zero_word;
		else if (load_tx)
			transmit_shift <= tx_holding;
		else if (shift_out)
			transmit_shift <= {transmit_shift[word_bits-2:0], 1'b0};
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			addr_out_shift <= 8'h00;
		else if (load_tx)
			addr_out_shift <= dest_transmit_addr;
		else if (shift_out)
			addr_out_shift <= {addr_out_shift[6:0], 1'b0};
	end

	// a load is dropped when the port is switched off
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			tx_loaded <= 1'b0;
		else if (!mode_en)
			tx_loaded <= 1'b0;
		else if (load_tx)
			tx_loaded <= 1'b1;
		else if (word_end)
			tx_loaded <= 1'b0;
	end

	// ---------------------------------------------
	// bus pins
	// ---------------------------------------------
	wire drive_dat = tx_loaded & mode_en;
	wire drive_adr = drive_dat & ~bit_cnt[3];

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bus_out <= '{1'b0, 1'b1, 1'b0, 1'b1};
		end else begin
			bus_out.dat_out <= transmit_shift[word_bits-1];
			bus_out.dat_oe_n <= ~drive_dat;
			bus_out.adr_out <= addr_out_shift[7];
			bus_out.adr_oe_n <= ~drive_adr;
		end
	end

	// ---------------------------------------------
	// register writes and flags
	// ---------------------------------------------
	// reserved upper bits of slot select read zero
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			slot_select <= zero_word;
		else if (wr_sel)
			slot_select <= {8'h00, req_in.wdata[7:0]};
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			rt_address <= zero_word;
		else if (wr_rta)
			rt_address <= req_in.wdata;
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			port_control <= zero_word;
		else if (wr_ctl)
			port_control <= {13'h0000, 2'h0, req_in.wdata[bit_mode_en]};
	end

	// ---------------------------------------------
	// holding registers and flags
	// ---------------------------------------------
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			tx_holding <= zero_word;
		else if (wr_txh)
			tx_holding <= req_in.wdata;
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			tx_full <= 1'b0;
		else if (wr_txh)
			tx_full <= 1'b1;
		else if (load_tx)
			tx_full <= 1'b0;
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			rx_holding <= zero_word;
		else if (rx_done)
			rx_holding <= {mux_receive_shift[word_bits-2:0], bdat};
	end

	// software read with the port off frees the holding word
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			rx_full <= 1'b0;
		else if (rx_done)
			rx_full <= 1'b1;
		else if (rd_rxh)
			rx_full <= 1'b0;
	end

	// set wins over the clearing read
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			align_seen <= 1'b0;
		else if (word_end)
			align_seen <= 1'b1;
		else if (rd_ast)
			align_seen <= 1'b0;
	end

	// ---------------------------------------------
	// interrupts
	// ---------------------------------------------
	// set wins over write-one-to-clear
	wire [1:0] irq_set = {load_tx, rx_done};
	wire [1:0] irq_clr = wr_ist ? req_in.wdata[1:0] : 2'h0;
	// level output, high while any unmasked event waits
	wire [1:0] irq_pending = irq_status & irq_mask;

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			irq_status <= 2'h0;
		else
			irq_status <= (irq_status & ~irq_clr) | irq_set;
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			irq_mask <= 2'h0;
		else if (wr_imk)
			irq_mask <= req_in.wdata[1:0];
	end
	assign irq_out = |irq_pending;

	// ---------------------------------------------
	// read mux
	// ---------------------------------------------
	wire tx_ready = ~tx_full;
	wire [data_w-1:0] ctl_view = {13'h0000, rx_full, tx_ready, mode_en};
	wire [data_w-1:0] rx_view = mode_en ? zero_word : rx_holding;
	wire [data_w-1:0] tx_view = mode_en ? zero_word : tx_holding;
	wire [data_w-1:0] irq_view = {14'h0000, irq_status};
	wire [data_w-1:0] mask_view = {14'h0000, irq_mask};
	// address hit, alignment seen, clock line, address line, address shift, bit position
	wire [data_w-1:0] addr_view = {addr_hit, align_seen, bclk, badr,
		addr_shift, bit_cnt};

	// ---------------------------------------------
	// read select
	// ---------------------------------------------
	logic [data_w-1:0] next_rdata;
	always_comb begin
		next_rdata = zero_word;
		if (req_in.rd) begin
			unique case (req_in.addr)
				off_slot_select: next_rdata = slot_select;
				off_rx_holding: next_rdata = rx_view;
				off_tx_holding: next_rdata = tx_view;
				off_addr_status: next_rdata = addr_view;
				off_rt_address: next_rdata = rt_address;
				off_port_control: next_rdata = ctl_view;
				off_irq_status: next_rdata = irq_view;
				off_irq_mask: next_rdata = mask_view;
				default: next_rdata = zero_word;
			endcase
		end
	end

	// ---------------------------------------------
	// read data register
	// ---------------------------------------------
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			rdata_out <= zero_word;
		else
			rdata_out <= next_rdata;
	end
endmodule

// ---- rtl/tdm_port_pkg.sv ----
// package for the multiplexed serial port: offsets, fields, types
// assumes a plain register port with 16-bit data in the low bits
//
// Notes on behaviour
// - transmit only in slots selected by low bits
// - receive holding hidden from software when enabled
// - transmit holding hidden from software when enabled
// - receive flag set on shift-to-holding copy
// - transmit flag set on holding-to-shift copy
// - low byte own address, high byte destination
// - control register bit zero is mode enable
// - address line marks which devices capture word
// - status register shows address line and alignment
// - mode bit enables, cleared bit disables port
package tdm_port_pkg;
	localparam int addr_w = 4;
	localparam int data_w = 16;
	localparam int word_bits = 16;
	localparam int slots = 8;
	localparam logic [addr_w-1:0] off_slot_select = 4'h0;
	localparam logic [addr_w-1:0] off_rx_holding = 4'h1;
	localparam logic [addr_w-1:0] off_tx_holding = 4'h2;
	localparam logic [addr_w-1:0] off_addr_status = 4'h3;
	localparam logic [addr_w-1:0] off_rt_address = 4'h4;
	localparam logic [addr_w-1:0] off_port_control = 4'h5;
	localparam logic [addr_w-1:0] off_irq_status = 4'h6;
	localparam logic [addr_w-1:0] off_irq_mask = 4'h7;
	localparam int bit_mode_en = 0;
	localparam int bit_tx_ready = 1;
	localparam int bit_rx_ready = 2;
	localparam int bit_irq_rx = 0;
	localparam int bit_irq_tx = 1;
	localparam logic [data_w-1:0] zero_word = 16'h0000;
	localparam logic [3:0] bit_cnt_last = 4'hf;
	localparam logic [2:0] slot_last = 3'h7;
	localparam logic [3:0] addr_bit_last = 4'h7;
	typedef struct packed {
		logic [addr_w-1:0] addr;
		logic [data_w-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic clk;
		logic dat;
		logic adr;
	} bus_in_t;
	typedef struct packed {
		logic dat_out;
		logic dat_oe_n;
		logic adr_out;
		logic adr_oe_n;
	} bus_out_t;
endpackage

// ---- verification/tdm_port_sva.sv ----
// checker for the multiplexed serial port, bound to its top module
// assumes one register strobe at a time on the request port
`timescale 1ns/10ps
module tdm_port_sva (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// ports watched
	input wire tdm_port_pkg::reg_req_t req_in,
	input wire logic [tdm_port_pkg::data_w-1:0] rdata_out,
	input wire tdm_port_pkg::bus_in_t bus_in,
	input wire tdm_port_pkg::bus_out_t bus_out,
	input wire logic irq_out
);
	import tdm_port_pkg::*;
	logic mode;
	logic [8:0] drv_run;
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mode <= 1'b0;
			drv_run <= 9'h000;
		end else begin
			if (req_in.wr && req_in.addr == off_port_control)
				mode <= req_in.wdata[bit_mode_en];
			drv_run <= bus_out.dat_oe_n ? 9'h000 : drv_run + 9'h001;
		end
	end
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!arst_n_in);
	AST_MASK_IRQ: assert property (req_in.wr &&
		req_in.addr == off_irq_mask && req_in.wdata[1:0] == 2'h0 |=> !irq_out)
		else $error("irq with mask clear");
	AST_OFF_RELEASE: assert property (!mode && !$past(mode) &&
		!$past(mode, 2) |-> bus_out.dat_oe_n && bus_out.adr_oe_n)
		else $error("pins driven with port off");
	AST_RX_HIDDEN: assert property (req_in.rd && mode &&
		req_in.addr == off_rx_holding |=> rdata_out == zero_word)
		else $error("rx holding visible");
	AST_TX_HIDDEN: assert property (req_in.rd && mode &&
		req_in.addr == off_tx_holding |=> rdata_out == zero_word)
		else $error("tx holding visible");
	AST_CTL_BACK: assert property (req_in.wr &&
		req_in.addr == off_port_control ##1 !req_in.wr ##1 req_in.rd &&
		req_in.addr == off_port_control |=> rdata_out[bit_mode_en] ==
		$past(req_in.wdata[bit_mode_en], 3)) else $error("mode readback");
	AST_SLOT_BACK: assert property (req_in.wr &&
		req_in.addr == off_slot_select ##1 !req_in.wr ##1 req_in.rd &&
		req_in.addr == off_slot_select |=> rdata_out[7:0] ==
		$past(req_in.wdata[7:0], 3)) else $error("slot readback");
	AST_ADDR_BACK: assert property (req_in.wr &&
		req_in.addr == off_rt_address ##1 !req_in.wr ##1 req_in.rd &&
		req_in.addr == off_rt_address |=> rdata_out ==
		$past(req_in.wdata, 3)) else $error("address readback");
	AST_SLOT_LEN: assert property (drv_run <= 9'h108)
		else $error("drive longer than a slot");
endmodule
bind tdm_multiprocessor_serial_port tdm_port_sva sva_i (
	.ref_clk_in(ref_clk_in),
	.arst_n_in(arst_n_in),
	.req_in(req_in),
	.rdata_out(rdata_out),
	.bus_in(bus_in),
	.bus_out(bus_out),
	.irq_out(irq_out)
);

// ---- verification/tdm_peer.sv ----
// second processor on the shared bus: makes the bus clock for one frame
// assumes line levels are resolved outside and fed back here
`timescale 1ns/10ps
module tdm_peer (
	input wire logic go_in,
	input wire logic dat_in,
	input wire logic adr_in,
	input wire logic dev_drv_in,
	output logic clk_out,
	output logic dat_out,
	output logic adr_out,
	output logic [23:0] seen_out,
	output int drv_cnt_out,
	output logic done_out
);
	initial begin
		clk_out = 1'b0;
		dat_out = 1'b0;
		adr_out = 1'b0;
		seen_out = 24'h000000;
		drv_cnt_out = 0;
		done_out = 1'b0;
		@(posedge go_in);
		// clock runs one frame of 128 bits, own slot five; idle lines toggle
		for (int i = 0; i < 128; i++) begin
			dat_out = (i / 16 == 5) ? 16'h96e1 >> (15 - i % 16) : i[0];
			adr_out = (i / 16 == 5 && i % 16 < 8) ? 8'h3c >> (7 - i % 16) : !i[0];
			#80 clk_out = 1'b1;
			if (i / 16 == 2 && i % 16 < 8)
				seen_out[23:16] = {seen_out[22:16], adr_in};
			if (i / 16 == 2)
				seen_out[15:0] = {seen_out[14:0], dat_in};
			drv_cnt_out += dev_drv_in;
			#80 clk_out = 1'b0;
		end
		done_out = 1'b1;
	end
endmodule

// ---- verification/tdm_multiprocessor_serial_port_test.sv ----
// bench for the multiplexed serial port with one peer on the bus
// assumes the peer model and the bound checker are compiled alongside
`timescale 1ns/10ps
module tdm_multiprocessor_serial_port_test;
	import tdm_port_pkg::*;
	logic ref_clk_in;
	logic arst_n_in = 1'b0;
	reg_req_t req = '0;
	logic [15:0] rdata;
	bus_out_t bo;
	logic irq, p_clk, p_dat, p_adr, p_done;
	logic go = 1'b0;
	logic [23:0] seen;
	int drv_cnt;
	int n_errors = 0;
	int total_checks = 0;
	// device wins the line while its output enable is low, else the peer's level
	wire bus_in_t bi = {p_clk, bo.dat_oe_n ? p_dat : bo.dat_out,
		bo.adr_oe_n ? p_adr : bo.adr_out};
	tdm_multiprocessor_serial_port dut (.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in), .req_in(req), .rdata_out(rdata),
		.bus_in(bi), .bus_out(bo), .irq_out(irq));
	tdm_peer peer (.go_in(go), .dat_in(bi.dat), .adr_in(bi.adr),
		.dev_drv_in(!bo.dat_oe_n), .clk_out(p_clk), .dat_out(p_dat),
		.adr_out(p_adr), .seen_out(seen), .drv_cnt_out(drv_cnt),
		.done_out(p_done));
	task automatic chk(input string n, input logic [15:0] s, e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic results;
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk_in);
		req <= '0;
		@(posedge ref_clk_in);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk_in);
		req <= '0;
		#1 d = rdata;
		@(posedge ref_clk_in);
	endtask
	task automatic t_regs;
		logic [15:0] d;
		wr(off_slot_select, 16'h0004);
		rd(off_slot_select, d);
		chk("slot_select", d & 16'h00ff, 16'h0004);
		wr(off_rt_address, 16'hc53c);
		rd(off_rt_address, d);
		chk("rt_address", d, 16'hc53c);
		rd(4'hf, d);
		chk("unmapped", d, 16'h0000);
		wr(off_irq_mask, 16'h0003);
		wr(off_tx_holding, 16'ha5f0);
		rd(off_tx_holding, d);
		chk("tx_holding", d, 16'ha5f0);
	endtask
	task automatic t_frame;
		logic [15:0] d;
		wr(off_port_control, 16'h0001);
		rd(off_port_control, d);
		chk("mode", d & 16'h0001, 16'h0001);
		rd(off_tx_holding, d);
		chk("tx hidden", d, 16'h0000);
		go <= 1'b1;
		for (int i = 0; i < 3000 && !p_done; i++)
			@(posedge ref_clk_in);
		if (p_done !== 1'b1) begin
			n_errors++;
			results();
		end
		chk("wire addr", {8'h00, seen[23:16]}, 16'h00c5);
		chk("wire word", seen[15:0], 16'ha5f0);
		chk("slot bits", drv_cnt[15:0], 16'h0010);
		chk("irq", {15'h0000, irq}, 16'h0001);
		rd(off_irq_status, d);
		chk("irq status", d & 16'h0003, 16'h0003);
		rd(off_port_control, d);
		chk("ready flags", d & 16'h0006, 16'h0006);
		rd(off_rx_holding, d);
		chk("rx hidden", d, 16'h0000);
		rd(off_addr_status, d);
		chk("addr status", d & 16'he00f, 16'h4000);
		rd(off_addr_status, d);
		chk("align cleared", d & 16'h4000, 16'h0000);
		wr(off_irq_mask, 16'h0000);
		wr(off_irq_status, 16'h0003);
		rd(off_irq_status, d);
		chk("irq clear", d & 16'h0003, 16'h0000);
		wr(off_port_control, 16'h0000);
		rd(off_rx_holding, d);
		chk("rx word", d, 16'h96e1);
		chk("release", {14'h0000, bo.dat_oe_n, bo.adr_oe_n}, 16'h0003);
	endtask
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		repeat (3) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		@(posedge ref_clk_in);
		t_regs();
		t_frame();
		results();
	end
endmodule
